// [eef_dev_end.sv]
/*
 * eeprom end of the two-wire link: start/stop detection, select decode
 * against the straps, acknowledge both ways, write cycle after a stop.
 * assumes linkClock far outruns scl; clock/sys_rst is the system side;
 * read data is the last data byte written, the array lies outside.
 */
`timescale 1ns/1ps
`default_nettype none

`include "eef_map.svh"

module eef_dev_end #(
	parameter logic [3:0] TYPE_CODE    = `EEF_TYPE_CODE, // arbitrary value
	parameter int         WRITE_CYCLES = `EEF_WRITE_TIME_NS / `EEF_CLOCK_NS
) (
	input  wire logic       linkClock,
	input  wire logic       clock,
	input  wire logic       sys_rst,
	eef_link_if.device      link,
	input  wire logic [2:0] selectStrap,
	input  wire logic       writeProtect,
	output logic            programStart,
	output logic            standbyEntered,
	output logic            programBusy
);

	localparam int CW = $clog2(WRITE_CYCLES + 1);

	generate
		if (WRITE_CYCLES < 1) begin : gBadWrite
			$error("eef_dev_end write time must be at least one cycle");
		end
	endgenerate

	eef_pkg::eef_dev_state_type state_reg;
	logic          linkRst;
	logic          sclS;
	logic          sdaS;
	logic [2:0]    strapS;
	logic          protectS;
	logic          busyS;
	logic          sclPrev_reg;
	logic          sdaPrev_reg;
	logic [3:0]    bitCnt_reg;
	logic [7:0]    shift_reg;
	logic [7:0]    store_reg;
	logic [1:0]    byteIdx_reg;
	logic          readCmd_reg;
	logic          session_reg;
	logic          dataAcked_reg;
	logic          afterAck_reg;
	logic          masterAck_reg;
	logic          oe_reg;
	logic          progTgl_reg;
	logic          stbyTgl_reg;
	logic          progPend_reg;
	logic          progS;
	logic          stbyS;
	logic [1:0]    evPrev_reg;
	logic [CW-1:0] wcount_reg;

	// ************************************************************
	// link-domain reset and pin synchronisers
	// ************************************************************
	eef_sync #(.WIDTH(1)) uRstSync (
		.clock    (linkClock),
		.rst      (1'b0),
		.levelIn  (sys_rst),
		.levelOut (linkRst)
	);

	eef_sync #(.WIDTH(7)) uPinSync (
		.clock    (linkClock),
		.rst      (linkRst),
		.levelIn  ({link.scl, link.sda, selectStrap, writeProtect, programBusy}),
		.levelOut ({sclS, sdaS, strapS, protectS, busyS})
	);

	// ************************************************************
	// line events and byte decode
	// ************************************************************
	wire sclRise   = sclS && !sclPrev_reg;
	wire sclFall   = !sclS && sclPrev_reg;
	wire startSeen = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
	wire stopSeen  = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
	wire linkBusy  = busyS || progPend_reg;
	wire byteDone  = (bitCnt_reg == `EEF_BITS_PER_BYTE);
	wire isSelect  = (byteIdx_reg == 2'h0);
	wire isData    = (byteIdx_reg == `EEF_DATA_BYTE_IDX);
	wire typeOk    = (shift_reg[`EEF_SEL_TYPE_LSB +: 4] == TYPE_CODE);
	wire chipOk    = (shift_reg[`EEF_SEL_CHIP_LSB +: 3] == strapS);
	wire selMatch  = typeOk && chipOk;
	wire giveAck   = isSelect ? selMatch : !(protectS && isData);
	wire goProgram = session_reg && !readCmd_reg && dataAcked_reg && afterAck_reg;
	wire [1:0] idxNext = isData ? byteIdx_reg : byteIdx_reg + 2'h1;

	// only ever pulls the data line low; the clock is never driven
	assign link.sdaOutDev = 1'b0;
	assign link.sdaOeDev  = oe_reg;

	// ************************************************************
	// serial engine
	// ************************************************************
	always_ff @(posedge linkClock) begin
		if (linkRst) begin
			state_reg     <= eef_pkg::DEV_IDLE;
			sclPrev_reg   <= 1'b0;
			sdaPrev_reg   <= 1'b0;
			bitCnt_reg    <= 4'h0;
			shift_reg     <= 8'h00;
			store_reg     <= `EEF_ERASED_BYTE;
			byteIdx_reg   <= 2'h0;
			readCmd_reg   <= 1'b0;
			session_reg   <= 1'b0;
			dataAcked_reg <= 1'b0;
			afterAck_reg  <= 1'b0;
			masterAck_reg <= 1'b0;
			oe_reg        <= 1'b0;
			progTgl_reg   <= 1'b0;
			stbyTgl_reg   <= 1'b0;
			progPend_reg  <= 1'b0;
		end else begin
			sclPrev_reg <= sclS; // line history for the edge detectors
			sdaPrev_reg <= sdaS;
			if (busyS) begin
				progPend_reg <= 1'b0;
			end
			if (stopSeen) begin
				state_reg   <= eef_pkg::DEV_IDLE;
				oe_reg      <= 1'b0;
				session_reg <= 1'b0;
				if (session_reg && readCmd_reg) begin
					stbyTgl_reg <= !stbyTgl_reg;
				end
				if (goProgram) begin
					progTgl_reg  <= !progTgl_reg;
					progPend_reg <= 1'b1;
				end
			end else if (startSeen && !linkBusy) begin
				state_reg     <= eef_pkg::DEV_RX;
				oe_reg        <= 1'b0;
				bitCnt_reg    <= 4'h0;
				byteIdx_reg   <= 2'h0;
				session_reg   <= 1'b0;
				dataAcked_reg <= 1'b0;
				afterAck_reg  <= 1'b0;
			end else begin
				unique case (state_reg)
					eef_pkg::DEV_IDLE: oe_reg <= 1'b0;
					eef_pkg::DEV_RX: begin
						if (sclRise && !byteDone) begin
							shift_reg  <= {shift_reg[6:0], sdaS};
							bitCnt_reg <= bitCnt_reg + 4'h1;
						end
						if (sclFall) begin
							afterAck_reg <= 1'b0;
						end
						if (sclFall && byteDone) begin
							oe_reg    <= giveAck;
							state_reg <= (isSelect && !selMatch) ? eef_pkg::DEV_IDLE
								: eef_pkg::DEV_RXACK;
							if (isSelect && selMatch) begin
								readCmd_reg <= shift_reg[`EEF_SEL_RW_BIT];
								session_reg <= 1'b1;
							end
							if (isData && giveAck) begin
								store_reg     <= shift_reg;
								dataAcked_reg <= 1'b1;
							end
						end
					end
					eef_pkg::DEV_RXACK: begin
						if (sclFall) begin
							bitCnt_reg   <= 4'h0;
							byteIdx_reg  <= idxNext;
							afterAck_reg <= 1'b1;
							if (isSelect && readCmd_reg) begin
								shift_reg  <= store_reg;
								oe_reg     <= !store_reg[7];
								bitCnt_reg <= 4'h1;
								state_reg  <= eef_pkg::DEV_TX;
							end else begin
								oe_reg    <= 1'b0;
								state_reg <= eef_pkg::DEV_RX;
							end
						end
					end
					eef_pkg::DEV_TX: begin
						if (sclFall && byteDone) begin
							oe_reg    <= 1'b0;
							state_reg <= eef_pkg::DEV_TXACK;
						end else if (sclFall) begin
							oe_reg     <= !shift_reg[6];
							shift_reg  <= {shift_reg[6:0], 1'b0};
							bitCnt_reg <= bitCnt_reg + 4'h1;
						end
					end
					eef_pkg::DEV_TXACK: begin
						if (sclRise) begin
							masterAck_reg <= !sdaS;
						end
						if (sclFall && masterAck_reg) begin
							shift_reg  <= store_reg;
							oe_reg     <= !store_reg[7];
							bitCnt_reg <= 4'h1;
							state_reg  <= eef_pkg::DEV_TX;
						end else if (sclFall) begin
							state_reg <= eef_pkg::DEV_IDLE;
						end
					end
					default: state_reg <= eef_pkg::DEV_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// system side: event crossing and write timer
	// ************************************************************
	eef_sync #(.WIDTH(2)) uEvSync (
		.clock    (clock),
		.rst      (sys_rst),
		.levelIn  ({progTgl_reg, stbyTgl_reg}),
		.levelOut ({progS, stbyS})
	);

	// toggles become one-cycle pulses
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			evPrev_reg     <= 2'b00;
			programStart   <= 1'b0;
			standbyEntered <= 1'b0;
		end else begin
			evPrev_reg     <= {progS, stbyS};
			programStart   <= progS ^ evPrev_reg[1];
			standbyEntered <= stbyS ^ evPrev_reg[0];
		end
	end

	// self-timed write cycle; busy returns to the link side
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			programBusy <= 1'b0;
			wcount_reg  <= '0;
		end else if (programStart) begin
			programBusy <= 1'b1;
			wcount_reg  <= CW'(WRITE_CYCLES - 1);
		end else if (programBusy) begin
			programBusy <= (wcount_reg != '0);
			wcount_reg  <= wcount_reg - 1'b1;
		end
	end

endmodule : eef_dev_end

`default_nettype wire

// [eef_map.svh]
/*
 * constants of the two-wire eeprom front end: select byte layout,
 * bit counts and the timing figures of the link.
 * assumes it is included by its bare name, before the package users.
 */
`ifndef EEF_MAP_SVH
`define EEF_MAP_SVH

// ************************************************************
// select byte layout
// ************************************************************
`define EEF_TYPE_CODE      4'h5      // arbitrary value, not a real part code
`define EEF_SEL_TYPE_LSB   4
`define EEF_SEL_CHIP_LSB   1
`define EEF_SEL_RW_BIT     0
`define EEF_BITS_PER_BYTE  4'h8
`define EEF_DATA_BYTE_IDX  2'h3      // select, two address bytes, then data
`define EEF_ERASED_BYTE    8'hff     // content of a byte never written

// ************************************************************
// timing
// ************************************************************
`define EEF_CLOCK_NS       50        // system clock period
`define EEF_SCL_PERIOD_NS  2500      // 400 kHz serial clock
`define EEF_BUS_FREE_NS    1300      // bus free time after a stop
`define EEF_WRITE_TIME_NS  10000000  // self-timed write cycle, 10 ms

`endif

// [eef_pkg.sv]
/*
 * types of the two-wire eeprom front end: the state codes of both ends.
 * assumes eef_map.svh carries the layout, bit count and timing constants; the state codes are numbered here.
 */
`default_nettype none

package eef_pkg;

	// ************************************************************
	// state codes
	// ************************************************************
	typedef enum logic [2:0] {
		DEV_IDLE  = 3'h0,
		DEV_RX    = 3'h1,
		DEV_RXACK = 3'h2,
		DEV_TX    = 3'h3,
		DEV_TXACK = 3'h4
	} eef_dev_state_type;

	typedef enum logic [2:0] {
		HOST_IDLE  = 3'h0,
		HOST_START = 3'h1,
		HOST_BIT   = 3'h2,
		HOST_STOP  = 3'h3,
		HOST_FREE  = 3'h4
	} eef_host_state_type;

endpackage : eef_pkg

`default_nettype wire

// [eef_link_if.sv]
/*
 * the two-wire link between bus master and eeprom front end.
 * assumes both ends only ever pull the data line low; the line level
 * is resolved here from the output enables, released means high.
 */
`timescale 1ns/1ps
`default_nettype none

interface eef_link_if;

	logic scl;         // serial clock, master only
	logic sdaOutHost;
	logic sdaOeHost;
	logic sdaOutDev;
	logic sdaOeDev;
	logic sda;         // resolved data line

	// wired-and of both open-drain drivers with a pull-up
	assign sda = !((sdaOeHost && !sdaOutHost) || (sdaOeDev && !sdaOutDev));

	modport host (output scl, output sdaOutHost, output sdaOeHost, input sda);
	modport device (input scl, input sda, output sdaOutDev, output sdaOeDev);

endinterface : eef_link_if

`default_nettype wire

// [eef_sync.sv]
/*
 * two flip-flop synchroniser for levels that enter a clock domain.
 * assumes each bit is an independent level; words need another scheme.
 */
`timescale 1ns/1ps
`default_nettype none

module eef_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] levelIn,
	output logic      [WIDTH-1:0] levelOut
);

	logic [WIDTH-1:0] meta_reg;

	generate
		if (WIDTH < 1) begin : gBadWidth
			$error("eef_sync needs a width of at least one");
		end
	endgenerate

	// first stage feeds only the second
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_reg <= '0;
			levelOut <= '0;
		end else begin
			meta_reg <= levelIn;
			levelOut <= meta_reg;
		end
	end

endmodule : eef_sync

`default_nettype wire

// [eef_host_end.sv]
/*
 * bus master end: makes the serial clock by a divider, frames start and
 * stop, and runs one write (select, two address bytes, one data byte)
 * or one read (select, one byte, no acknowledge) per request.
 * assumes requests come from logic on clock; the data line is a pin.
 */
`timescale 1ns/1ps
`default_nettype none

`include "eef_map.svh"

module eef_host_end #(
	parameter logic [3:0] TYPE_CODE      = `EEF_TYPE_CODE, // arbitrary value
	parameter int         QUARTER_CYCLES =
		(`EEF_SCL_PERIOD_NS / 4 + `EEF_CLOCK_NS - 1) / `EEF_CLOCK_NS,
	parameter int         FREE_CYCLES    =
		(`EEF_BUS_FREE_NS + `EEF_CLOCK_NS - 1) / `EEF_CLOCK_NS
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	eef_link_if.host         link,
	input  wire logic        reqValid,
	output logic             reqReady,
	input  wire logic        reqRead,
	input  wire logic [2:0]  reqChip,
	input  wire logic [15:0] reqAddr,
	input  wire logic [7:0]  reqData,
	output logic             doneValid,
	output logic             doneAck,
	output logic [7:0]       rdData
);

	localparam int CMAX = (QUARTER_CYCLES > FREE_CYCLES) ? QUARTER_CYCLES : FREE_CYCLES;
	localparam int CW   = $clog2(CMAX + 1);

	generate
		if (QUARTER_CYCLES < 1 || FREE_CYCLES < 1) begin : gBadTiming
			$error("eef_host_end timing counts must be at least one");
		end
	endgenerate

	eef_pkg::eef_host_state_type state_reg;
	logic [CW-1:0] cnt_reg;
	logic [1:0]    phase_reg;
	logic [3:0]    bit_reg;
	logic [1:0]    byteNo_reg;
	logic          read_reg;
	logic [2:0]    chip_reg;
	logic [15:0]   addr_reg;
	logic [7:0]    data_reg;
	logic [7:0]    txShift_reg;
	logic [7:0]    rxShift_reg;
	logic          scl_reg;
	logic          oe_reg;
	logic          allAck_reg;
	logic          nack_reg;
	logic          sdaS;

	// ************************************************************
	// pin input and decode
	// ************************************************************
	eef_sync #(.WIDTH(1)) uSdaSync (
		.clock    (clock),
		.rst      (sys_rst),
		.levelIn  (link.sda),
		.levelOut (sdaS)
	);

	// byte to transmit at each position of a write
	function automatic logic [7:0] pickByte(input logic [1:0] idx, input logic [15:0] a,
		input logic [7:0] d);
		unique case (idx)
			2'h1: pickByte = a[15:8];
			2'h2: pickByte = a[7:0];
			default: pickByte = d;
		endcase
	endfunction : pickByte

	wire       tick     = (cnt_reg == '0);
	wire       txing    = !(read_reg && byteNo_reg == 2'h1);
	wire       lastByte = read_reg ? (byteNo_reg == 2'h1) : (byteNo_reg == 2'h3);
	wire [1:0] nextNo   = byteNo_reg + 2'h1;
	wire [7:0] selByte  = {TYPE_CODE, chip_reg, read_reg};

	assign reqReady        = (state_reg == eef_pkg::HOST_IDLE);
	assign link.scl        = scl_reg;
	assign link.sdaOutHost = 1'b0;
	assign link.sdaOeHost  = oe_reg;

	// ************************************************************
	// quarter-period divider and bus sequencer
	// ************************************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg   <= eef_pkg::HOST_IDLE;
			cnt_reg     <= '0;
			phase_reg   <= 2'h0;
			bit_reg     <= 4'h0;
			byteNo_reg  <= 2'h0;
			read_reg    <= 1'b0;
			chip_reg    <= 3'h0;
			addr_reg    <= 16'h0000;
			data_reg    <= 8'h00;
			txShift_reg <= 8'h00;
			rxShift_reg <= 8'h00;
			scl_reg     <= 1'b1;
			oe_reg      <= 1'b0;
			allAck_reg  <= 1'b0;
			nack_reg    <= 1'b0;
			doneValid   <= 1'b0;
			doneAck     <= 1'b0;
			rdData      <= 8'h00;
		end else begin
			doneValid <= 1'b0;
			cnt_reg   <= tick ? CW'(QUARTER_CYCLES - 1) : cnt_reg - 1'b1;
			if (tick && state_reg != eef_pkg::HOST_IDLE) begin
				phase_reg <= phase_reg + 2'h1;
			end
			unique case (state_reg)
				eef_pkg::HOST_IDLE: begin
					cnt_reg <= CW'(QUARTER_CYCLES - 1);
					if (reqValid) begin
						read_reg   <= reqRead;
						chip_reg   <= reqChip;
						addr_reg   <= reqAddr;
						data_reg   <= reqData;
						phase_reg  <= 2'h0;
						allAck_reg <= 1'b1;
						state_reg  <= eef_pkg::HOST_START;
					end
				end
				eef_pkg::HOST_START: if (tick) begin
					if (phase_reg == 2'h1) begin
						oe_reg <= 1'b1; // data falls, clock high
					end else if (phase_reg == 2'h3) begin
						scl_reg     <= 1'b0;
						bit_reg     <= 4'h0;
						byteNo_reg  <= 2'h0;
						txShift_reg <= selByte;
						state_reg   <= eef_pkg::HOST_BIT;
					end
				end
				eef_pkg::HOST_BIT: if (tick) begin
					unique case (phase_reg)
						2'h0: oe_reg <= txing && bit_reg != 4'h8 && !txShift_reg[7];
						2'h1: scl_reg <= 1'b1;
						2'h2: begin
							if (bit_reg != 4'h8) begin
								rxShift_reg <= {rxShift_reg[6:0], sdaS};
								txShift_reg <= {txShift_reg[6:0], 1'b0};
							end else begin
								nack_reg <= txing && sdaS;
								if (txing && sdaS) begin
									allAck_reg <= 1'b0;
								end
							end
						end
						2'h3: begin
							scl_reg <= 1'b0;
							bit_reg <= bit_reg + 4'h1;
							if (bit_reg == 4'h8) begin
								bit_reg <= 4'h0;
								if (nack_reg || lastByte) begin
									state_reg <= eef_pkg::HOST_STOP;
								end else begin
									byteNo_reg  <= nextNo;
									txShift_reg <= pickByte(nextNo, addr_reg, data_reg);
								end
							end
						end
					endcase
				end
				eef_pkg::HOST_STOP: if (tick) begin
					if (phase_reg == 2'h0) begin
						oe_reg <= 1'b1;
					end else if (phase_reg == 2'h1) begin
						scl_reg <= 1'b1;
					end else if (phase_reg == 2'h3) begin
						oe_reg    <= 1'b0; // data rises, clock high
						cnt_reg   <= CW'(FREE_CYCLES - 1);
						doneValid <= 1'b1;
						doneAck   <= allAck_reg;
						rdData    <= rxShift_reg;
						state_reg <= eef_pkg::HOST_FREE;
					end
				end
				eef_pkg::HOST_FREE: begin
					if (tick) begin
						state_reg <= eef_pkg::HOST_IDLE;
					end
				end
				default: state_reg <= eef_pkg::HOST_IDLE;
			endcase
		end
	end

endmodule : eef_host_end

`default_nettype wire

// [eef_link_monitor.sv]
/* link checker: watches the two-wire link between the two ends.
   assumes linkClock oversamples scl and sda, sys_rst is the run's reset. */
`timescale 1ns/1ps
`default_nettype none

module eef_link_monitor (
	input wire logic linkClock,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sdaOeHost,
	input wire logic sdaOeDev,
	input wire logic sda
);
	// ************************************************************
	// frame tracking
	// ************************************************************
	logic       sclQ_reg;
	logic       sdaQ_reg;
	logic       idle_reg;
	logic [5:0] rises_reg;
	logic [3:0] oeRises_reg;
	wire        sclRise = scl && !sclQ_reg;
	wire        startEv = scl && sclQ_reg && sdaQ_reg && !sda;
	wire        stopEv  = scl && sclQ_reg && !sdaQ_reg && sda;

	// clock rises since start, rises while the device pulls, idle after stop
	always_ff @(posedge linkClock) begin
		sclQ_reg <= scl;
		sdaQ_reg <= sda;
		if (sys_rst || startEv) rises_reg <= 6'h00;
		else if (sclRise && rises_reg != 6'h3f) rises_reg <= rises_reg + 6'h01;
		if (sys_rst || !sdaOeDev) oeRises_reg <= 4'h0;
		else if (sclRise && oeRises_reg != 4'hf) oeRises_reg <= oeRises_reg + 4'h1;
		if (sys_rst || stopEv) idle_reg <= 1'b1;
		else if (startEv) idle_reg <= 1'b0;
	end

	default clocking dc @(posedge linkClock); endclocking
	default disable iff (sys_rst);

	// ************************************************************
	// link rules
	// ************************************************************
	a_oe_steady_high: assert property (scl && sclQ_reg |-> $stable(sdaOeDev))
		else $error("device data moved while clock high");
	a_ack_clock_low: assert property ($rose(sdaOeDev) |-> !scl)
		else $error("device pull began while clock high");
	a_select_quiet: assert property (!idle_reg && rises_reg < 6'h08 |-> !sdaOeDev)
		else $error("device pulled during select byte");
	a_tx_release: assert property (oeRises_reg <= 4'h9)
		else $error("device held data past eight bits");
	a_stop_quiet: assert property (idle_reg |-> !sdaOeDev)
		else $error("device pulled after stop");
	a_idle_clock_high: assert property (idle_reg |-> scl)
		else $error("clock not high between frames");
	a_host_edge_ok: assert property ($changed(sdaOeHost) && scl && sclQ_reg |-> !sdaOeDev)
		else $error("host data moved under device pull");
	a_frame_bits: assert property (rises_reg <= 6'h25)
		else $error("frame longer than a write");

	c_write: cover property (stopEv && rises_reg == 6'h25);
	c_read: cover property (stopEv && rises_reg == 6'h13);
	c_ack: cover property ($rose(sdaOeDev) && rises_reg == 6'h08);
endmodule : eef_link_monitor

`default_nettype wire

// [eeprom_i2c_slave_front_end_test.sv]
/* testbench: host end and device end joined by the link.
   assumes the design files and eef_link_monitor are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module eeprom_i2c_slave_front_end_test;
	localparam int WR_CYC = 200;
	logic       clock        = 1'b0;
	logic       linkClock    = 1'b0;
	logic       sys_rst      = 1'b1;
	logic       reqValid     = 1'b0;
	logic       reqRead      = 1'b0;
	logic [2:0] reqChip      = 3'h0;
	logic [7:0] reqData      = 8'h00;
	logic [2:0] selectStrap  = 3'h0;
	logic       writeProtect = 1'b0;
	logic       reqReady;
	logic       doneValid;
	logic       doneAck;
	logic [7:0] rdData;
	logic       programStart;
	logic       standbyEntered;
	logic       programBusy;
	int         n_errors     = 0;
	int         n_tests      = 0;
	int         progCnt      = 0;
	int         stbyCnt      = 0;
	int         busyCnt      = 0;

	// system clock and free link sampling clock
	always #25 clock = ~clock;
	initial begin
		#1.7;
		forever #3 linkClock = ~linkClock;
	end

	// pulse and busy tallies
	always @(negedge clock) begin
		if (programStart === 1'b1) progCnt++;
		if (standbyEntered === 1'b1) stbyCnt++;
		if (programBusy === 1'b1) busyCnt++;
	end

	eef_link_if link ();
	eef_host_end eef_host_end_inst (.clock(clock), .sys_rst(sys_rst), .link(link.host),
		.reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead), .reqChip(reqChip),
		.reqAddr(16'h1234), .reqData(reqData), .doneValid(doneValid), .doneAck(doneAck),
		.rdData(rdData));
	eef_dev_end #(.WRITE_CYCLES(WR_CYC)) eef_dev_end_inst (.linkClock(linkClock),
		.clock(clock), .sys_rst(sys_rst), .link(link.device), .selectStrap(selectStrap),
		.writeProtect(writeProtect), .programStart(programStart),
		.standbyEntered(standbyEntered), .programBusy(programBusy));
	eef_link_monitor eef_link_monitor_inst (.linkClock(linkClock), .sys_rst(sys_rst),
		.scl(link.scl), .sdaOeHost(link.sdaOeHost), .sdaOeDev(link.sdaOeDev), .sda(link.sda));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// bounded wait at falling edges; a run-out ends the run
	task automatic wait_for(ref logic flag, input logic level, input int bound);
		int i;
		i = 0;
		while (flag !== level) begin
			@(negedge clock);
			i++;
			if (i > bound) begin
				n_errors++;
				report_and_stop();
			end
		end
	endtask : wait_for

	// one transfer, then bus free time and the program pulse latency
	task automatic do_req(input logic rd, input logic [2:0] chip, input logic [7:0] data,
		output logic ack, output logic [7:0] rx);
		wait_for(reqReady, 1'b1, 200);
		@(posedge clock);
		reqRead <= rd;
		reqChip <= chip;
		reqData <= data;
		reqValid <= 1'b1;
		@(posedge clock);
		reqValid <= 1'b0;
		wait_for(doneValid, 1'b1, 4000);
		ack = doneAck;
		rx = rdData;
		repeat (40) @(negedge clock);
	endtask : do_req

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_straps;
		logic       ack;
		logic [7:0] rx;
		int         p;
		for (int s = 0; s < 8; s++) begin
			@(posedge clock);
			selectStrap <= s[2:0];
			p = progCnt;
			do_req(1'b0, s[2:0] ^ 3'(1 << (s % 3)), 8'h00, ack, rx);
			check("foreign chip ack", ack, 1'b0);
			do_req(1'b0, s[2:0], {5'h15, s[2:0]}, ack, rx);
			check("own chip ack", ack, 1'b1);
			check("program count", progCnt - p, 1);
			wait_for(programBusy, 1'b0, 400);
		end
		$display("test straps done");
	endtask : t_straps

	task automatic t_busy;
		logic       ack;
		logic [7:0] rx;
		int         b;
		int         sb;
		b = busyCnt;
		do_req(1'b0, 3'h7, 8'h4b, ack, rx);
		check("write ack", ack, 1'b1);
		do_req(1'b1, 3'h7, 8'h00, ack, rx);
		check("select while busy", ack, 1'b0);
		wait_for(programBusy, 1'b0, 400);
		check("busy length", busyCnt - b, WR_CYC);
		b = progCnt;
		sb = stbyCnt;
		do_req(1'b1, 3'h7, 8'h00, ack, rx);
		check("read ack", ack, 1'b1);
		check("read byte", rx, 8'h4b);
		check("standby", stbyCnt - sb, 1);
		check("no program on read", progCnt - b, 0);
		$display("test busy done");
	endtask : t_busy

	task automatic t_protect;
		logic       ack;
		logic [7:0] rx;
		int         p;
		p = progCnt;
		@(posedge clock);
		writeProtect <= 1'b1;
		do_req(1'b0, 3'h7, 8'h99, ack, rx);
		check("protected ack", ack, 1'b0);
		check("protected program", progCnt - p, 0);
		@(posedge clock);
		writeProtect <= 1'b0;
		do_req(1'b1, 3'h7, 8'h00, ack, rx);
		check("kept byte", rx, 8'h4b);
		$display("test protect done");
	endtask : t_protect

	// reset, scenarios, verdict
	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (10) @(posedge clock);
		t_straps();
		t_busy();
		t_protect();
		report_and_stop();
	end
endmodule : eeprom_i2c_slave_front_end_test

`default_nettype wire
